// *** sasq_analog_model.sv ***
// Behavioural analog front end: input bank, sample-hold, comparator
module sasq_analog_model
(
  input  wire logic       i_clk,
  input  wire logic       i_sample,
  input  wire logic [2:0] i_channel,
  input  wire logic [9:0] i_tap,
  output logic            o_comp_ge
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] vin [8] = '{default: 10'h000};
  logic [9:0] held = 10'h000;
  // Held value frozen once sampling ends
  always @(posedge i_clk) begin
    if (i_sample) begin
      held <= vin[i_channel];
    end
  end
  // Ideal comparator needs no minimum conversion time
  // Combinational so the design's sync latency is the only delay
  assign o_comp_ge = (held >= i_tap);
endmodule

// *** sasq_pkg.sv ***
// Shared constants and types for the SAR converter sequencer
package sasq_pkg;

  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned RES_BITS    = 10;
  localparam int unsigned STEP_W      = 4;
  localparam int unsigned CHAN_W      = 3;

  // Register byte addresses
  localparam logic [15:0] MODE_OFFSET     = 16'hff80;
  localparam logic [15:0] CHAN_OFFSET     = 16'hff84;
  localparam logic [15:0] RESULT_LO_OFF   = 16'hff14;
  localparam logic [15:0] RESULT_HI_OFF   = 16'hff15;

  // Reset values
  localparam logic [7:0]  MODE_RESET      = 8'h00;
  localparam logic [7:0]  CHAN_RESET      = 8'h00;
  localparam logic [15:0] RESULT_RESET    = 16'h0000;

  // Mode register fields
  localparam int unsigned MODE_ENABLE_BIT = 7;
  localparam int unsigned MODE_TIME_LSB   = 3;
  localparam int unsigned MODE_BIAS_BIT   = 0;
  localparam logic [7:0]  MODE_RW_MASK    = 8'hb9;
  localparam logic [7:0]  CHAN_RW_MASK    = 8'h07;

  // Result alignment: ten bits left-aligned in sixteen
  localparam int unsigned RESULT_SHIFT    = 6;

  // Conversion lengths in main-clock cycles per time code
  localparam int unsigned CONV_CYC_144    = 144;
  localparam int unsigned CONV_CYC_120    = 120;
  localparam int unsigned CONV_CYC_96     = 96;
  localparam int unsigned CONV_CYC_72     = 72;
  localparam int unsigned CONV_CYC_60     = 60;
  localparam int unsigned CONV_CYC_48     = 48;
  // Two sample units plus ten comparison units
  localparam int unsigned SAMPLE_UNITS    = 2;
  localparam int unsigned UNITS_PER_CONV  = SAMPLE_UNITS + RES_BITS;

  localparam logic [9:0]  SAR_FIRST_TRIAL = 10'h200;

  typedef enum logic [2:0] {
    SASQ_IDLE   = 3'b001,
    SASQ_SAMPLE = 3'b010,
    SASQ_CMP    = 3'b100
  } sasq_state_type;

  // Cycles of one unit for a time code; prohibited codes use the longest
  function automatic logic [STEP_W-1:0] sasq_unit_cycles(
    input logic [2:0] code
  );
    int unsigned n;
    n = CONV_CYC_144;
    case (code)
      3'h0:    n = CONV_CYC_144;
      3'h1:    n = CONV_CYC_120;
      3'h2:    n = CONV_CYC_96;
      3'h4:    n = CONV_CYC_72;
      3'h5:    n = CONV_CYC_60;
      3'h6:    n = CONV_CYC_48;
      default: n = CONV_CYC_144;
    endcase
    return STEP_W'(n / UNITS_PER_CONV);
  endfunction

endpackage

// *** sasq_reg_if.sv ***
// Carrier between register file and conversion sequencer
interface sasq_reg_if;
  import sasq_pkg::*;

  logic [7:0]          mode;
  logic [CHAN_W-1:0]   chan;
  logic                cfg_write;
  logic                done;
  logic [RES_BITS-1:0] sar_value;

  modport regs (
    output mode,
    output chan,
    output cfg_write,
    input  done,
    input  sar_value
  );

  modport seq (
    input  mode,
    input  chan,
    input  cfg_write,
    output done,
    output sar_value
  );
endinterface

// *** sasq_regs.sv ***
// Processor-facing mode, channel and result registers
module sasq_regs
  import sasq_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic [ADDR_W-1:0]    i_bus_addr,
  input  wire logic                 i_bus_wr,
  input  wire logic [DATA_W-1:0]    i_bus_wmask,
  input  wire logic [DATA_W-1:0]    i_bus_wdata,
  input  wire logic                 i_bus_rd,
  output logic      [15:0]          o_bus_rdata,
  output logic                      o_irq,
  sasq_reg_if.regs                  cif
);
  import sasq_pkg::*;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    return a == off;
  endfunction

  logic [7:0]  mode;
  logic [7:0]  chan;
  logic [15:0] result;
  logic [15:0] next_rdata;

  wire mode_wr = i_bus_wr && hit(i_bus_addr, MODE_OFFSET);
  wire chan_wr = i_bus_wr && hit(i_bus_addr, CHAN_OFFSET);
  // Bit writes carry a one-hot mask, byte writes carry all ones
  wire [7:0] mode_new = ((mode & ~i_bus_wmask) | (i_bus_wdata & i_bus_wmask))
                        & MODE_RW_MASK;
  wire [7:0] chan_new = ((chan & ~i_bus_wmask) | (i_bus_wdata & i_bus_wmask))
                        & CHAN_RW_MASK;
  // A configuration write beats a finishing conversion
  wire take_result = cif.done && !(mode_wr || chan_wr);
  wire [15:0] aligned = {cif.sar_value, 6'h00};

  assign cif.mode      = mode;
  assign cif.chan      = chan[CHAN_W-1:0];
  assign cif.cfg_write = mode_wr || chan_wr;

  always_comb begin
    next_rdata = 16'h0000;
    if (hit(i_bus_addr, MODE_OFFSET)) begin
      next_rdata = {8'h00, mode};
    end else if (hit(i_bus_addr, CHAN_OFFSET)) begin
      next_rdata = {8'h00, chan};
    end else if (hit(i_bus_addr, RESULT_LO_OFF)) begin
      next_rdata = result;
    end else if (hit(i_bus_addr, RESULT_HI_OFF)) begin
      next_rdata = {8'h00, result[15:8]};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode <= MODE_RESET;
      chan <= CHAN_RESET;
    end else begin
      if (mode_wr) begin
        mode <= mode_new;
      end
      if (chan_wr) begin
        chan <= chan_new;
      end
    end
  end

  // Read samples the old value, so a read racing an update is served first
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result      <= RESULT_RESET;
      o_bus_rdata <= 16'h0000;
      o_irq       <= 1'b0;
    end else begin
      if (i_bus_rd) begin
        o_bus_rdata <= next_rdata;
      end
      if (take_result) begin
        result <= aligned;
      end
      o_irq <= take_result;
    end
  end
endmodule

// *** sasq_top.sv ***
// SAR converter sequencer top: reset, comparator sync and bit sequencing
//
// Overview of operation
// - Mode register resets to zero; bit and byte writes both accepted.
// - Enable bit 7 set starts converting the selected channel; clear disables.
// - Time code in bits 5..3 picks 144/120/96/72/60/48 clock cycles.
// - Mode bit 0 runs or stops the reference bias circuit.
// - Channel register resets to zero; bit and byte writes both accepted.
// - Channel bits 2..0 pick input 0 to 7 in straight binary.
// - After sample and hold, bits resolve MSB first from half scale.
// - Trial bit kept when input at or above tap, else cleared.
// - All ten bits done: result latched and end request raised together.
// - Finished conversion restarts automatically until disabled or rewritten.
// - Mode or channel write cancels a conversion; restarts if still enabled.
// - Mode write with enable zero stops conversion at once.
// - Reset clears the result register to zero.
// - Standby halts the converter.
// - Start only by software register write or by leaving standby with enable set; single channel select operation.
// - Result sits left-aligned in sixteen bits, low six bits zero.
// - A result read racing an update is served before the update.
// - A configuration write racing an update wins; no update, no request.
module sasq_top
  import sasq_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic [ADDR_W-1:0]    i_bus_addr,
  input  wire logic                 i_bus_wr,
  input  wire logic [DATA_W-1:0]    i_bus_wmask,
  input  wire logic [DATA_W-1:0]    i_bus_wdata,
  input  wire logic                 i_bus_rd,
  output logic      [15:0]          o_bus_rdata,
  input  wire logic                 i_standby,
  input  wire logic                 i_comp_ge,
  output logic                      o_bias_enable,
  output logic                      o_sample,
  output logic      [CHAN_W-1:0]    o_channel,
  output logic      [RES_BITS-1:0]  o_tap,
  output logic                      o_conv_active,
  output logic                      o_conversion_end_irq
);
  import sasq_pkg::*;

  logic rst_s1;
  logic rst_n_sync;

  // Assert at once, release through two flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1     <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_s1     <= 1'b1;
      rst_n_sync <= rst_s1;
    end
  end

  sasq_reg_if cif ();

  sasq_regs u_regs (
    .i_clk       (i_clk),
    .i_rst_n     (rst_n_sync),
    .i_bus_addr  (i_bus_addr),
    .i_bus_wr    (i_bus_wr),
    .i_bus_wmask (i_bus_wmask),
    .i_bus_wdata (i_bus_wdata),
    .i_bus_rd    (i_bus_rd),
    .o_bus_rdata (o_bus_rdata),
    .o_irq       (o_conversion_end_irq),
    .cif         (cif)
  );

  // Comparator and standby come from outside the clock domain
  logic cmp_s1;
  logic cmp_s2;
  logic cmp_s3;
  logic cmp_q;
  logic sby_s1;
  logic sby_s2;
  logic sby_s3;
  logic sby_q;

  always_ff @(posedge i_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_s3 <= 1'b0;
      cmp_q  <= 1'b0;
      sby_s1 <= 1'b0;
      sby_s2 <= 1'b0;
      sby_s3 <= 1'b0;
      sby_q  <= 1'b0;
    end else begin
      cmp_s1 <= i_comp_ge;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      sby_s1 <= i_standby;
      sby_s2 <= sby_s1;
      sby_s3 <= sby_s2;
      if (cmp_s2 == cmp_s3) begin
        cmp_q <= cmp_s3;
      end
      if (sby_s2 == sby_s3) begin
        sby_q <= sby_s3;
      end
    end
  end

  sasq_state_type      state;
  sasq_state_type      next_state;
  logic [STEP_W-1:0]   cnt;
  logic                unit;
  logic [3:0]          bit_idx;
  logic [RES_BITS-1:0] sar;
  logic                done;
  logic [RES_BITS-1:0] done_value;

  wire [STEP_W-1:0] unit_len =
    sasq_unit_cycles(cif.mode[MODE_TIME_LSB +: 3]);
  wire run      = cif.mode[MODE_ENABLE_BIT] && !sby_q;
  wire unit_end = (cnt == unit_len - STEP_W'(1));
  // Trial bit decided from the comparator at the end of each unit
  // Comparator taken once the last two stages agree, a cycle ahead of
  // the filtered flop, so a four-cycle unit still sees its own tap
  wire cmp_now = (cmp_s2 == cmp_s3) ? cmp_s3 : cmp_q;
  wire [RES_BITS-1:0] decided =
    cmp_now ? sar : (sar & ~(RES_BITS'(1) << bit_idx));
  wire last_bit = (bit_idx == 4'h0);
  wire first_trial = (state == SASQ_SAMPLE) && (next_state == SASQ_CMP);
  wire step_trial  = (state == SASQ_CMP) && (next_state == SASQ_CMP)
                     && unit_end;
  wire [RES_BITS-1:0] next_trial =
    decided | (RES_BITS'(1) << (bit_idx - 4'h1));
  // Tap leaves on the deciding edge; a late tap would eat the sync margin
  wire [RES_BITS-1:0] next_sar =
    first_trial ? SAR_FIRST_TRIAL : (step_trial ? next_trial : sar);

  always_comb begin
    next_state = state;
    case (state)
      SASQ_IDLE: begin
        // Opens a conversion in any cycle that is enabled, not halted and free of a config write
        if (run && !cif.cfg_write) begin
          next_state = SASQ_SAMPLE;
        end
      end
      SASQ_SAMPLE: begin
        if (unit_end && unit) begin
          next_state = SASQ_CMP;
        end
      end
      SASQ_CMP: begin
        if (unit_end && last_bit) begin
          next_state = SASQ_SAMPLE;
        end
      end
      default: next_state = SASQ_IDLE;
    endcase
    // Any config write cancels; a disabled or halted run stops at once
    if (cif.cfg_write || !run) begin
      next_state = SASQ_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state <= SASQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      cnt        <= '0;
      unit       <= 1'b0;
      bit_idx    <= 4'h9;
      sar        <= '0;
      done       <= 1'b0;
      done_value <= '0;
    end else begin
      done <= 1'b0;
      if (state != next_state || state == SASQ_IDLE) begin
        cnt <= '0;
      end else if (unit_end) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + STEP_W'(1);
      end
      if (next_state == SASQ_SAMPLE && state != SASQ_SAMPLE) begin
        unit <= 1'b0;
      end else if (state == SASQ_SAMPLE && unit_end) begin
        unit <= 1'b1;
      end
      if (first_trial) begin
        sar     <= next_sar;
        bit_idx <= 4'h9;
      end else if (step_trial) begin
        sar     <= next_sar;
        bit_idx <= bit_idx - 4'h1;
      end else if (state == SASQ_CMP && unit_end && last_bit) begin
        sar        <= decided;
        done_value <= decided;
        // A write or halt on the deciding edge drops the report
        done       <= (next_state == SASQ_SAMPLE);
      end
    end
  end

  assign cif.done      = done;
  assign cif.sar_value = done_value;

  always_ff @(posedge i_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      o_bias_enable <= 1'b0;
      o_sample      <= 1'b0;
      o_channel     <= '0;
      o_tap         <= '0;
      o_conv_active <= 1'b0;
    end else begin
      o_bias_enable <= cif.mode[MODE_BIAS_BIT] && !sby_q;
      o_sample      <= (next_state == SASQ_SAMPLE);
      o_channel     <= cif.chan;
      o_tap         <= (next_state == SASQ_CMP) ? next_sar : '0;
      o_conv_active <= (next_state != SASQ_IDLE);
    end
  end
endmodule

// *** sasq_top_checker.sv ***
// Port-level assertions for the converter sequencer top
module sasq_top_checker
(
  input wire logic                          i_clk,
  input wire logic                          i_rst_n,
  input wire logic [sasq_pkg::ADDR_W-1:0]   i_bus_addr,
  input wire logic                          i_bus_wr,
  input wire logic [sasq_pkg::DATA_W-1:0]   i_bus_wmask,
  input wire logic [sasq_pkg::DATA_W-1:0]   i_bus_wdata,
  input wire logic                          i_standby,
  input wire logic                          o_bias_enable,
  input wire logic                          o_sample,
  input wire logic [sasq_pkg::RES_BITS-1:0] o_tap,
  input wire logic                          o_conv_active,
  input wire logic                          o_conversion_end_irq
);
  import sasq_pkg::*;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  wire cfg_wr = i_bus_wr && (i_bus_addr == MODE_OFFSET ||
                             i_bus_addr == CHAN_OFFSET);
  wire en_wr = i_bus_wr && i_bus_addr == MODE_OFFSET && i_bus_wmask[7];
  // Standby must have been low long enough to clear its synchroniser
  sequence s_start;
    (!i_standby) [*6] ##0 (en_wr && i_bus_wdata[7]);
  endsequence
  // Sample phase is 2U and U is at least 4
  sequence s_sample_run;
    (o_sample || !o_conv_active) [*8];
  endsequence
  a_irq_one_pulse:
    assert property (o_conversion_end_irq |=> !o_conversion_end_irq)
    else $error("end request wider than one cycle");
  a_cfg_wr_no_irq:
    assert property (cfg_wr |=> (!o_conversion_end_irq) [*8])
    else $error("end request soon after a config write");
  a_disable_stops:
    assert property (en_wr && !i_bus_wdata[7] |-> ##2 !o_conv_active)
    else $error("conversion still active after disable");
  a_enable_starts:
    assert property (s_start |-> ##2 (o_sample && o_conv_active))
    else $error("enable write did not start sampling");
  a_first_trial:
    assert property ($fell(o_sample) && o_conv_active |->
                     o_tap == SAR_FIRST_TRIAL)
    else $error("first trial is not half scale");
  a_sample_len:
    assert property ($rose(o_sample) |-> s_sample_run)
    else $error("sample phase too short");
  a_standby_halts:
    assert property (i_standby [*6] |-> !o_conv_active && !o_bias_enable)
    else $error("converter runs in standby");
  a_irq_active:
    assert property (o_conversion_end_irq |-> $past(o_conv_active))
    else $error("end request without a conversion");
endmodule

bind sasq_top sasq_top_checker u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus_addr(i_bus_addr),
  .i_bus_wr(i_bus_wr), .i_bus_wmask(i_bus_wmask),
  .i_bus_wdata(i_bus_wdata), .i_standby(i_standby),
  .o_bias_enable(o_bias_enable), .o_sample(o_sample), .o_tap(o_tap),
  .o_conv_active(o_conv_active),
  .o_conversion_end_irq(o_conversion_end_irq)
);

// *** sasq_top_tb.sv ***
// Self-checking bench for the converter sequencer
module sasq_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sasq_pkg::*;
  logic              i_clk = 1'b0;
  logic              i_rst_n = 1'b0;
  logic [15:0]       i_bus_addr = 16'h0000;
  logic              i_bus_wr = 1'b0;
  logic [7:0]        i_bus_wmask = 8'h00;
  logic [7:0]        i_bus_wdata = 8'h00;
  logic              i_bus_rd = 1'b0;
  logic              i_standby = 1'b0;
  logic              comp_ge;
  logic [15:0]       o_bus_rdata;
  logic              o_bias_enable;
  logic              o_sample;
  logic [2:0]        o_channel;
  logic [9:0]        o_tap;
  logic              o_conv_active;
  logic              o_irq;
  int                mismatches = 0;
  int                n_checks = 0;
  logic [2:0]        codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  int                cycs [6] = '{144, 120, 96, 72, 60, 48};
  logic [9:0]        vals [6] = '{10'h3ff, 10'h000, 10'h2aa, 10'h155,
                                  10'h200, 10'h1ff};

  always #2 i_clk = ~i_clk;

  sasq_top dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus_addr(i_bus_addr),
    .i_bus_wr(i_bus_wr), .i_bus_wmask(i_bus_wmask),
    .i_bus_wdata(i_bus_wdata), .i_bus_rd(i_bus_rd),
    .o_bus_rdata(o_bus_rdata), .i_standby(i_standby),
    .i_comp_ge(comp_ge), .o_bias_enable(o_bias_enable),
    .o_sample(o_sample), .o_channel(o_channel), .o_tap(o_tap),
    .o_conv_active(o_conv_active), .o_conversion_end_irq(o_irq)
  );
  sasq_analog_model model (
    .i_clk(i_clk), .i_sample(o_sample), .i_channel(o_channel),
    .i_tap(o_tap), .o_comp_ge(comp_ge)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] m,
                        input logic [7:0] d);
    @(posedge i_clk);
    i_bus_addr <= a;
    i_bus_wmask <= m;
    i_bus_wdata <= d;
    i_bus_wr <= 1'b1;
    @(posedge i_clk);
    i_bus_wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_bus_addr <= a;
    i_bus_rd <= 1'b1;
    @(posedge i_clk);
    i_bus_rd <= 1'b0;
    #1;
    d = o_bus_rdata;
  endtask

  // Edges until the end request shows, capped at lim
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (o_irq !== 1'b1 && n < lim);
  endtask

  task automatic t_regs;
    logic [15:0] d;
    bus_rd(MODE_OFFSET, d);
    chk(d, 16'h0000);
    bus_rd(CHAN_OFFSET, d);
    chk(d, 16'h0000);
    bus_rd(RESULT_LO_OFF, d);
    chk(d, 16'h0000);
    bus_wr(MODE_OFFSET, 8'hff, 8'h29);
    bus_rd(MODE_OFFSET, d);
    chk(d, 16'h0029);
    chk({15'h0, o_bias_enable}, 16'h0001);
    bus_wr(MODE_OFFSET, 8'h01, 8'h00);
    bus_rd(MODE_OFFSET, d);
    chk(d, 16'h0028);
    chk({15'h0, o_bias_enable}, 16'h0000);
    bus_wr(CHAN_OFFSET, 8'hff, 8'h05);
    bus_rd(CHAN_OFFSET, d);
    chk(d, 16'h0005);
    bus_wr(16'hff88, 8'hff, 8'h80);
    bus_rd(16'hff88, d);
    chk(d, 16'h0000);
    chk({15'h0, o_conv_active}, 16'h0000);
  endtask

  task automatic t_conv(input int i);
    int n;
    logic [15:0] d;
    model.vin[i] = vals[i];
    bus_wr(CHAN_OFFSET, 8'hff, 8'(i));
    bus_wr(MODE_OFFSET, 8'hff, {2'b10, codes[i], 3'b001});
    wait_irq(400, n);
    chk({13'h0, o_channel}, 16'(i));
    wait_irq(400, n);
    chk(16'(n), 16'(cycs[i]));
    bus_rd(RESULT_LO_OFF, d);
    chk(d, {vals[i], 6'h00});
    bus_rd(RESULT_HI_OFF, d);
    chk(d, {8'h00, vals[i][9:2]});
  endtask

  task automatic t_cancel;
    int n;
    logic [15:0] d;
    model.vin[6] = 10'h2c7;
    wait_irq(100, n);
    repeat (20) @(posedge i_clk);
    bus_wr(CHAN_OFFSET, 8'hff, 8'h06);
    wait_irq(100, n);
    chk(16'(n >= 44 && n <= 54), 16'h0001);
    bus_rd(RESULT_LO_OFF, d);
    chk(d, {10'h2c7, 6'h00});
    bus_wr(MODE_OFFSET, 8'h80, 8'h00);
    wait_irq(200, n);
    chk(16'(n), 16'd200);
    chk({15'h0, o_conv_active}, 16'h0000);
  endtask

  task automatic t_standby;
    int n;
    bus_wr(MODE_OFFSET, 8'h80, 8'h80);
    wait_irq(100, n);
    chk(16'(n < 100), 16'h0001);
    @(posedge i_clk);
    i_standby <= 1'b1;
    wait_irq(150, n);
    chk(16'(n), 16'd150);
    chk({14'h0, o_conv_active, o_bias_enable}, 16'h0000);
    @(posedge i_clk);
    i_standby <= 1'b0;
    wait_irq(150, n);
    chk(16'(n < 150), 16'h0001);
  endtask

  // Read, then write, landing on the result store of a 48-cycle run
  task automatic t_race;
    int n;
    logic [15:0] d;
    bus_wr(MODE_OFFSET, 8'hff, 8'hb1);
    wait_irq(100, n);
    model.vin[6] = 10'h0f3;
    wait_irq(100, n);
    model.vin[6] = 10'h30c;
    repeat (46) @(posedge i_clk);
    bus_rd(RESULT_LO_OFF, d);
    chk(d, {10'h0f3, 6'h00});
    chk({15'h0, o_irq}, 16'h0001);
    bus_rd(RESULT_LO_OFF, d);
    chk(d, {10'h30c, 6'h00});
    wait_irq(100, n);
    model.vin[6] = 10'h1c3;
    repeat (46) @(posedge i_clk);
    bus_wr(CHAN_OFFSET, 8'hff, 8'h06);
    bus_rd(RESULT_LO_OFF, d);
    chk(d, {10'h30c, 6'h00});
    wait_irq(100, n);
    chk(16'(n), 16'd48);
    bus_rd(RESULT_LO_OFF, d);
    chk(d, {10'h1c3, 6'h00});
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_regs;
    for (int i = 0; i < 6; i++) begin
      t_conv(i);
    end
    t_cancel;
    t_standby;
    t_race;
    wrap_up;
  end

  // Whole sequence needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    wrap_up;
  end
endmodule
